//--- include/power_ctl_pkg.sv
// Constants and types shared by the power-down mode controller.
package power_ctl_pkg;

	// Operating modes, one-hot
	typedef enum logic [5:0] {
		MODE_RUN = 6'h01,
		MODE_SLEEP = 6'h02,
		MODE_SW_STANDBY = 6'h04,
		MODE_SETTLE = 6'h08,
		MODE_RESET = 6'h10,
		MODE_HW_STANDBY = 6'h20
	} mode_t;

	// Standby-select bit value that picks software standby
	localparam logic DEEP_SLEEP_SELECT_STANDBY = 1'h1;
	localparam logic DEEP_SLEEP_SELECT_RESET = 1'h0;

	// Wake edge select: 0 falling, 1 rising
	localparam logic WAKE_EDGE_FALLING = 1'h0;
	localparam logic WAKE_EDGE_RISING = 1'h1;

	// Settle-wait codes
	localparam logic [2:0] SETTLE_CODE_8K = 3'h0;
	localparam logic [2:0] SETTLE_CODE_16K = 3'h1;
	localparam logic [2:0] SETTLE_CODE_32K = 3'h2;
	localparam logic [2:0] SETTLE_CODE_64K = 3'h3;
	localparam logic [2:0] SETTLE_CODE_128K = 3'h4;
	localparam logic [2:0] SETTLE_CODE_256K = 3'h5;
	localparam logic [2:0] SETTLE_CODE_1K = 3'h6;
	localparam logic [2:0] SETTLE_CODE_ILLEGAL = 3'h7;

	// Settle wait lengths in divided system-clock states
	localparam int unsigned SETTLE_STATES_8K = 8192;
	localparam int unsigned SETTLE_STATES_16K = 16384;
	localparam int unsigned SETTLE_STATES_32K = 32768;
	localparam int unsigned SETTLE_STATES_64K = 65536;
	localparam int unsigned SETTLE_STATES_128K = 131072;
	localparam int unsigned SETTLE_STATES_256K = 262144;
	localparam int unsigned SETTLE_STATES_1K = 1024;

	// Width of the state counter, holds 262144 - 1
	localparam int unsigned SETTLE_CNT_W = 19;
	// Width of the prescale counter, divide by up to 8
	localparam int unsigned PRESCALE_CNT_W = 3;

	// Number of peripheral clock enables
	localparam int unsigned PERIPH_N = 8;

endpackage

//--- rtl/settle_timer.sv
// Oscillator settling timer counting divided system-clock states.
`timescale 1ns/1ps
`default_nettype none

module settle_timer #(
	parameter int unsigned STATES_8K = power_ctl_pkg::SETTLE_STATES_8K,
	parameter int unsigned STATES_16K = power_ctl_pkg::SETTLE_STATES_16K,
	parameter int unsigned STATES_32K = power_ctl_pkg::SETTLE_STATES_32K,
	parameter int unsigned STATES_64K = power_ctl_pkg::SETTLE_STATES_64K,
	parameter int unsigned STATES_128K = power_ctl_pkg::SETTLE_STATES_128K,
	parameter int unsigned STATES_256K = power_ctl_pkg::SETTLE_STATES_256K
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic start_i,
	input wire logic abort_i,
	input wire logic [2:0] code_i,
	input wire logic [1:0] prescale_i,
	output logic done_o
);

	typedef struct packed {
		logic busy;
		logic [power_ctl_pkg::PRESCALE_CNT_W-1:0] pre;
		logic [power_ctl_pkg::SETTLE_CNT_W-1:0] states;
		logic done;
	} timer_t;

	timer_t cur;
	timer_t next_cur;

	// Wait length minus one; illegal code waits the STATES_256K length
	function automatic logic [power_ctl_pkg::SETTLE_CNT_W-1:0] wait_last(input logic [2:0] code);
		int unsigned n;
		unique case (code)
			power_ctl_pkg::SETTLE_CODE_8K: n = STATES_8K;
			power_ctl_pkg::SETTLE_CODE_16K: n = STATES_16K;
			power_ctl_pkg::SETTLE_CODE_32K: n = STATES_32K;
			power_ctl_pkg::SETTLE_CODE_64K: n = STATES_64K;
			power_ctl_pkg::SETTLE_CODE_128K: n = STATES_128K;
			power_ctl_pkg::SETTLE_CODE_256K: n = STATES_256K;
			power_ctl_pkg::SETTLE_CODE_1K: n = power_ctl_pkg::SETTLE_STATES_1K;
			power_ctl_pkg::SETTLE_CODE_ILLEGAL: n = STATES_256K;
		endcase
		return power_ctl_pkg::SETTLE_CNT_W'(n - 1);
	endfunction

	logic [power_ctl_pkg::PRESCALE_CNT_W-1:0] pre_last;
	logic tick;

	// Each prescale step doubles the state length
	assign pre_last = power_ctl_pkg::PRESCALE_CNT_W'((4'h1 << prescale_i) - 4'h1);
	assign tick = cur.busy && (cur.pre == pre_last);

	always_comb begin
		next_cur = cur;
		next_cur.done = 1'h0;
		if (abort_i) begin
			next_cur.busy = 1'h0;
		end else if (start_i) begin
			next_cur.busy = 1'h1;
			next_cur.pre = '0;
			next_cur.states = wait_last(code_i);
		end else if (cur.busy) begin
			next_cur.pre = tick ? '0 : cur.pre + 1'h1;
			if (tick) begin
				if (cur.states == '0) begin
					next_cur.busy = 1'h0;
					next_cur.done = 1'h1;
				end else begin
					next_cur.states = cur.states - 1'h1;
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign done_o = cur.done;

endmodule // settle_timer

`default_nettype wire

//--- rtl/sleep_standby_power_control.sv
// Sleep and software standby mode controller with wake, reset and standby pin handling.
//
// Summary of operation
// - Halt instruction with select 0 enters sleep
// - Sleep halts CPU; DMA, DRAM, peripherals run
// - Module-stopped peripherals stay stopped in sleep
// - Accepted interrupt ends sleep, starts exception
// - Peripheral-disabled interrupt source never wakes sleep
// - Priority or CPU-masked maskable interrupt never wakes
// - Reset pin low in sleep enters reset
// - Standby pin low in sleep enters hardware standby
// - Halt instruction with select 1 enters standby
// - Standby stops clocks; resets DMA and peripherals
// - Standby holds ports, DRAM; refresh state initialized
// - Wake restarts oscillator, settles, then exception
// - Settle code and prescale choose wait length
// - Disabled or CPU-masked external lines never wake
// - Reset pin starts clocks; release starts reset
// - Standby pin low in standby enters hardware standby
// - Ports keep driving their state in standby
// - Wake edge select picks falling or rising edge
// - Select bit stays set; only write, reset pin or RST_N_I reset clears
`timescale 1ns/1ps
`default_nettype none

module sleep_standby_power_control #(
	parameter int unsigned SETTLE_STATES_8K = power_ctl_pkg::SETTLE_STATES_8K,
	parameter int unsigned SETTLE_STATES_16K = power_ctl_pkg::SETTLE_STATES_16K,
	parameter int unsigned SETTLE_STATES_32K = power_ctl_pkg::SETTLE_STATES_32K,
	parameter int unsigned SETTLE_STATES_64K = power_ctl_pkg::SETTLE_STATES_64K,
	parameter int unsigned SETTLE_STATES_128K = power_ctl_pkg::SETTLE_STATES_128K,
	parameter int unsigned SETTLE_STATES_256K = power_ctl_pkg::SETTLE_STATES_256K
) (
	input wire logic MCLK_I,
	input wire logic RST_N_I,
	// CPU side
	input wire logic SLEEP_EXEC_I,
	input wire logic SELECT_WR_I,
	input wire logic SELECT_WDATA_I,
	input wire logic [2:0] SETTLE_WAIT_SELECT_I,
	input wire logic [1:0] CLOCK_PRESCALE_BITS_I,
	input wire logic WAKE_EDGE_SELECT_I,
	input wire logic [power_ctl_pkg::PERIPH_N-1:0] MODULE_STOP_I,
	// Interrupt controller side
	input wire logic IRQ_REQ_I,
	input wire logic IRQ_SRC_EN_I,
	input wire logic IRQ_PRIO_MASKED_I,
	input wire logic CPU_IRQ_MASKED_I,
	input wire logic [2:0] EXT_WAKE_EN_I,
	// Pins
	input wire logic NMI_LINE_I,
	input wire logic [2:0] EXT_WAKE_LINE_I,
	input wire logic HARD_INIT_PIN_N_I,
	input wire logic DEEP_POWERDOWN_PIN_N_I,
	// Control outputs
	output logic CPU_HALT_O,
	output logic CPU_CLK_EN_O,
	output logic DMA_CLK_EN_O,
	output logic DRAM_CLK_EN_O,
	output logic [power_ctl_pkg::PERIPH_N-1:0] PERIPH_CLK_EN_O,
	output logic DMA_RESET_O,
	output logic PERIPH_RESET_O,
	output logic OSC_EN_O,
	output logic PORT_HOLD_O,
	output logic REFRESH_INIT_O,
	output logic INT_EXCEPTION_O,
	output logic RESET_EXCEPTION_O,
	output logic RESET_STATE_O,
	output logic HW_STANDBY_O,
	output logic DEEP_SLEEP_SELECT_O,
	output logic [5:0] POWER_MODE_O
);

	typedef struct packed {
		power_ctl_pkg::mode_t mode;
		logic nmi_prev;
		logic deep_sleep_select;
		logic int_exc;
		logic rst_exc;
		logic refresh_init;
		logic settle_start;
	} ctl_t;

	ctl_t cur;
	ctl_t next_cur;

	logic settle_done;
	logic nmi_rise;
	logic nmi_fall;
	logic nmi_event;
	logic ext_wake;
	logic maskable_wake;
	logic sleep_wake;
	logic in_sw_standby;

	// Edge of the non-maskable line chosen by the edge select
	assign nmi_rise = NMI_LINE_I && !cur.nmi_prev;
	assign nmi_fall = !NMI_LINE_I && cur.nmi_prev;
	assign nmi_event = (WAKE_EDGE_SELECT_I == power_ctl_pkg::WAKE_EDGE_RISING)
		? nmi_rise : nmi_fall;

	// External lines count only when enabled and not masked by the CPU
	assign ext_wake = (|(EXT_WAKE_LINE_I & EXT_WAKE_EN_I)) && !CPU_IRQ_MASKED_I;

	// Maskable request gated by source enable, priority and CPU mask
	assign maskable_wake = IRQ_REQ_I && IRQ_SRC_EN_I
		&& !IRQ_PRIO_MASKED_I && !CPU_IRQ_MASKED_I;

	assign sleep_wake = nmi_event || maskable_wake || ext_wake;

	always_comb begin
		next_cur = cur;
		next_cur.nmi_prev = NMI_LINE_I;
		next_cur.int_exc = 1'h0;
		next_cur.rst_exc = 1'h0;
		next_cur.refresh_init = 1'h0;
		next_cur.settle_start = 1'h0;

		// Only a software write or the reset pin changes the select bit
		if (SELECT_WR_I) begin
			next_cur.deep_sleep_select = SELECT_WDATA_I;
		end

		if (!DEEP_POWERDOWN_PIN_N_I) begin
			// Hardware standby overrides every other mode
			next_cur.mode = power_ctl_pkg::MODE_HW_STANDBY;
		end else if (!HARD_INIT_PIN_N_I) begin
			// Reset pin low restarts the oscillator and clocks at once
			next_cur.mode = power_ctl_pkg::MODE_RESET;
			next_cur.deep_sleep_select = power_ctl_pkg::DEEP_SLEEP_SELECT_RESET;
		end else begin
			unique case (cur.mode)
				power_ctl_pkg::MODE_RUN: begin
					if (SLEEP_EXEC_I) begin
						if (cur.deep_sleep_select == power_ctl_pkg::DEEP_SLEEP_SELECT_STANDBY) begin
							next_cur.mode = power_ctl_pkg::MODE_SW_STANDBY;
							next_cur.refresh_init = 1'h1;
						end else begin
							next_cur.mode = power_ctl_pkg::MODE_SLEEP;
						end
					end
				end
				power_ctl_pkg::MODE_SLEEP: begin
					if (sleep_wake) begin
						next_cur.mode = power_ctl_pkg::MODE_RUN;
						next_cur.int_exc = 1'h1;
					end
				end
				power_ctl_pkg::MODE_SW_STANDBY: begin
					if (nmi_event || ext_wake) begin
						next_cur.mode = power_ctl_pkg::MODE_SETTLE;
						next_cur.settle_start = 1'h1;
					end
				end
				power_ctl_pkg::MODE_SETTLE: begin
					if (settle_done) begin
						// Select bit is left as it is
						next_cur.mode = power_ctl_pkg::MODE_RUN;
						next_cur.int_exc = 1'h1;
					end
				end
				power_ctl_pkg::MODE_RESET: begin
					// Pin released: reset exception handling
					next_cur.mode = power_ctl_pkg::MODE_RUN;
					next_cur.rst_exc = 1'h1;
				end
				power_ctl_pkg::MODE_HW_STANDBY: begin
					// Leaving hardware standby passes through reset
					next_cur.mode = power_ctl_pkg::MODE_RESET;
				end
			endcase
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			cur.mode <= power_ctl_pkg::MODE_RUN;
			cur.nmi_prev <= 1'h0;
			cur.deep_sleep_select <= power_ctl_pkg::DEEP_SLEEP_SELECT_RESET;
			cur.int_exc <= 1'h0;
			cur.rst_exc <= 1'h0;
			cur.refresh_init <= 1'h0;
			cur.settle_start <= 1'h0;
		end else begin
			cur <= next_cur;
		end
	end

	settle_timer #(
		.STATES_8K(SETTLE_STATES_8K),
		.STATES_16K(SETTLE_STATES_16K),
		.STATES_32K(SETTLE_STATES_32K),
		.STATES_64K(SETTLE_STATES_64K),
		.STATES_128K(SETTLE_STATES_128K),
		.STATES_256K(SETTLE_STATES_256K)
	) u_settle_timer (
		.clk_i(MCLK_I),
		.rst_n_i(RST_N_I),
		.start_i(cur.settle_start),
		.abort_i(cur.mode != power_ctl_pkg::MODE_SETTLE),
		.code_i(SETTLE_WAIT_SELECT_I),
		.prescale_i(CLOCK_PRESCALE_BITS_I),
		.done_o(settle_done)
	);

	assign in_sw_standby = (cur.mode == power_ctl_pkg::MODE_SW_STANDBY)
		|| (cur.mode == power_ctl_pkg::MODE_SETTLE);

	// CPU stops in sleep and both standby modes; registers are untouched
	assign CPU_HALT_O = (cur.mode != power_ctl_pkg::MODE_RUN);
	assign CPU_CLK_EN_O = (cur.mode == power_ctl_pkg::MODE_RUN)
		|| (cur.mode == power_ctl_pkg::MODE_RESET);

	// DMA and DRAM keep clocks in sleep, lose them in standby
	assign DMA_CLK_EN_O = !in_sw_standby
		&& (cur.mode != power_ctl_pkg::MODE_HW_STANDBY);
	assign DRAM_CLK_EN_O = DMA_CLK_EN_O;

	// Module-stopped peripherals stay stopped in every mode
	assign PERIPH_CLK_EN_O = {power_ctl_pkg::PERIPH_N{DMA_CLK_EN_O}} & ~MODULE_STOP_I;

	// DMA and peripherals held in reset while in software standby
	assign DMA_RESET_O = in_sw_standby;
	assign PERIPH_RESET_O = in_sw_standby;

	// Oscillator off in software standby until a wake request and in hardware standby
	assign OSC_EN_O = (cur.mode != power_ctl_pkg::MODE_SW_STANDBY)
		&& (cur.mode != power_ctl_pkg::MODE_HW_STANDBY);

	// Ports keep their levels and drive through standby
	assign PORT_HOLD_O = in_sw_standby;
	assign REFRESH_INIT_O = cur.refresh_init;

	assign INT_EXCEPTION_O = cur.int_exc;
	assign RESET_EXCEPTION_O = cur.rst_exc;
	assign RESET_STATE_O = (cur.mode == power_ctl_pkg::MODE_RESET);
	assign HW_STANDBY_O = (cur.mode == power_ctl_pkg::MODE_HW_STANDBY);
	assign DEEP_SLEEP_SELECT_O = cur.deep_sleep_select;
	assign POWER_MODE_O = cur.mode;

endmodule // sleep_standby_power_control

`default_nettype wire

//--- dv/far_side_model.sv
// Behavioural model of the reset pin source and the non-maskable wake line.
`timescale 1ns/1ps
`default_nettype none

module far_side_model #(
	parameter int HOLD = 20
) (
	input wire logic clk_i,
	input wire logic init_req_i,
	input wire logic nmi_tgl_i,
	output logic init_pin_n_o,
	output logic nmi_o
);
	int cnt = 0;
	logic pin_n = 1'b1;
	logic lvl = 1'b0;
	always @(posedge clk_i) begin
		if (nmi_tgl_i) lvl <= !lvl;
		if (init_req_i) cnt <= HOLD;
		else if (cnt > 0) cnt <= cnt - 1;
		// Pin stays low until the oscillator has had time to settle
		pin_n <= !(init_req_i || cnt > 1);
	end
	assign init_pin_n_o = pin_n;
	assign nmi_o = lvl;
endmodule // far_side_model

`default_nettype wire

//--- dv/power_ctl_assertions.sv
// Port-level checker for the power-down mode controller.
`timescale 1ns/1ps
`default_nettype none

module power_ctl_chk (
	input wire logic MCLK_I,
	input wire logic RST_N_I,
	input wire logic SLEEP_EXEC_I,
	input wire logic SELECT_WR_I,
	input wire logic WAKE_EDGE_SELECT_I,
	input wire logic [power_ctl_pkg::PERIPH_N-1:0] MODULE_STOP_I,
	input wire logic IRQ_REQ_I,
	input wire logic IRQ_SRC_EN_I,
	input wire logic IRQ_PRIO_MASKED_I,
	input wire logic CPU_IRQ_MASKED_I,
	input wire logic [2:0] EXT_WAKE_EN_I,
	input wire logic NMI_LINE_I,
	input wire logic [2:0] EXT_WAKE_LINE_I,
	input wire logic HARD_INIT_PIN_N_I,
	input wire logic DEEP_POWERDOWN_PIN_N_I,
	input wire logic CPU_HALT_O,
	input wire logic CPU_CLK_EN_O,
	input wire logic DMA_CLK_EN_O,
	input wire logic DRAM_CLK_EN_O,
	input wire logic [power_ctl_pkg::PERIPH_N-1:0] PERIPH_CLK_EN_O,
	input wire logic DMA_RESET_O,
	input wire logic PERIPH_RESET_O,
	input wire logic OSC_EN_O,
	input wire logic PORT_HOLD_O,
	input wire logic REFRESH_INIT_O,
	input wire logic INT_EXCEPTION_O,
	input wire logic RESET_EXCEPTION_O,
	input wire logic RESET_STATE_O,
	input wire logic HW_STANDBY_O,
	input wire logic DEEP_SLEEP_SELECT_O,
	input wire logic [5:0] POWER_MODE_O
);
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (!RST_N_I);
	// One-hot mode codes
	wire run = POWER_MODE_O == 6'h01;
	wire slp = POWER_MODE_O == 6'h02;
	wire ssb = POWER_MODE_O == 6'h04;
	wire stl = POWER_MODE_O == 6'h08;
	wire pins = HARD_INIT_PIN_N_I && DEEP_POWERDOWN_PIN_N_I;
	wire irq_ok = IRQ_REQ_I && IRQ_SRC_EN_I && !IRQ_PRIO_MASKED_I && !CPU_IRQ_MASKED_I;
	wire ext = |(EXT_WAKE_LINE_I & EXT_WAKE_EN_I) && !CPU_IRQ_MASKED_I;

	sleep_entry_a: assert property (run && pins && SLEEP_EXEC_I && !DEEP_SLEEP_SELECT_O |=> slp)
		else $error("halt with select 0 missed sleep");
	standby_entry_a: assert property (run && pins && SLEEP_EXEC_I && DEEP_SLEEP_SELECT_O
		|=> ssb && REFRESH_INIT_O) else $error("halt with select 1 missed standby");
	sleep_outputs_a: assert property (slp |-> CPU_HALT_O && !CPU_CLK_EN_O && DMA_CLK_EN_O
		&& DRAM_CLK_EN_O && PERIPH_CLK_EN_O == ~MODULE_STOP_I) else $error("sleep outputs wrong");
	irq_wake_a: assert property (slp && pins && irq_ok |=> run && INT_EXCEPTION_O)
		else $error("accepted interrupt did not end sleep");
	masked_hold_a: assert property (slp && pins && !irq_ok && !ext && $stable(NMI_LINE_I)
		|=> slp) else $error("masked source left sleep");
	init_pin_a: assert property (!HARD_INIT_PIN_N_I && DEEP_POWERDOWN_PIN_N_I |=>
		POWER_MODE_O == 6'h10 && RESET_STATE_O && OSC_EN_O && CPU_CLK_EN_O && !DEEP_SLEEP_SELECT_O)
		else $error("reset pin low not taken");
	reset_exit_a: assert property (POWER_MODE_O == 6'h10 && pins |=> run && RESET_EXCEPTION_O)
		else $error("reset pin release did not start reset handling");
	hw_standby_a: assert property (!DEEP_POWERDOWN_PIN_N_I |=> POWER_MODE_O == 6'h20
		&& HW_STANDBY_O && !OSC_EN_O) else $error("standby pin low not taken");
	standby_state_a: assert property (ssb |-> !OSC_EN_O && !CPU_CLK_EN_O && DMA_RESET_O
		&& PERIPH_RESET_O && PORT_HOLD_O && PERIPH_CLK_EN_O == '0) else $error("standby outputs");
	ext_wake_a: assert property (ssb && pins && ext |=> stl && OSC_EN_O)
		else $error("enabled wake line did not start settling");
	standby_hold_a: assert property (ssb && pins && !ext && $stable(NMI_LINE_I) |=> ssb)
		else $error("standby left without wake");
	edge_wake_a: assert property (ssb && pins && WAKE_EDGE_SELECT_I && $rose(NMI_LINE_I)
		|=> stl) else $error("rising edge did not wake");
	fall_wake_a: assert property (ssb && pins && !WAKE_EDGE_SELECT_I && $fell(NMI_LINE_I)
		|=> stl) else $error("falling edge did not wake");
	select_hold_a: assert property (!SELECT_WR_I && pins && !POWER_MODE_O[5]
		|=> $stable(DEEP_SLEEP_SELECT_O)) else $error("select bit changed without write");

	cover property (slp ##1 INT_EXCEPTION_O);
	cover property (stl ##1 stl);
	cover property (RESET_EXCEPTION_O);
endmodule // power_ctl_chk

bind sleep_standby_power_control power_ctl_chk chk (.*);

`default_nettype wire

//--- dv/sleep_standby_power_control_tb_top.sv
// Self-checking bench for the power-down mode controller.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; \
	$display("[FAIL] %s exp %0h got %0h", n, e, g); end end

module sleep_standby_power_control_tb_top;
	logic clk = 0, rst_n = 0, sx = 0, swr = 0, swd = 0, eg = 0, irq = 0, sen = 0, prm = 0;
	logic cpm = 0, dpn = 1, itg = 0, ntg = 0;
	logic [2:0] sw = '0, een = '0, ext = '0;
	logic [1:0] pd = '0;
	logic [7:0] ms = '0;
	wire nmi, ipn, halt, osc, intx, rstx, sel, hws;
	wire [7:0] pclk;
	wire [5:0] pmode;
	int fails = 0, samples_checked = 0, lat, cyc = 0, k, c, e;
	int st[8] = '{8192, 16, 32, 64, 128, 256, 1024, 256};

	// Short waits keep the run brief; the 8192-state code keeps its real length
	sleep_standby_power_control #(.SETTLE_STATES_16K(16),
		.SETTLE_STATES_32K(32), .SETTLE_STATES_64K(64), .SETTLE_STATES_128K(128),
		.SETTLE_STATES_256K(256)) dut (.MCLK_I(clk), .RST_N_I(rst_n), .SLEEP_EXEC_I(sx),
		.SELECT_WR_I(swr), .SELECT_WDATA_I(swd), .SETTLE_WAIT_SELECT_I(sw),
		.CLOCK_PRESCALE_BITS_I(pd), .WAKE_EDGE_SELECT_I(eg), .MODULE_STOP_I(ms),
		.IRQ_REQ_I(irq), .IRQ_SRC_EN_I(sen), .IRQ_PRIO_MASKED_I(prm), .CPU_IRQ_MASKED_I(cpm),
		.EXT_WAKE_EN_I(een), .NMI_LINE_I(nmi), .EXT_WAKE_LINE_I(ext), .HARD_INIT_PIN_N_I(ipn),
		.DEEP_POWERDOWN_PIN_N_I(dpn), .CPU_HALT_O(halt), .CPU_CLK_EN_O(), .DMA_CLK_EN_O(),
		.DRAM_CLK_EN_O(), .PERIPH_CLK_EN_O(pclk), .DMA_RESET_O(), .PERIPH_RESET_O(),
		.OSC_EN_O(osc), .PORT_HOLD_O(), .REFRESH_INIT_O(), .INT_EXCEPTION_O(intx),
		.RESET_EXCEPTION_O(rstx), .RESET_STATE_O(), .HW_STANDBY_O(hws),
		.DEEP_SLEEP_SELECT_O(sel), .POWER_MODE_O(pmode));

	far_side_model far (.clk_i(clk), .init_req_i(itg), .nmi_tgl_i(ntg),
		.init_pin_n_o(ipn), .nmi_o(nmi));

	task stp(int n);
		repeat (n) @(negedge clk);
	endtask
	task go(string n, logic [5:0] m);
		for (lat = 0; lat < 20000 && pmode !== m; lat++) @(negedge clk);
		`CHK(n, m, pmode)
	endtask
	task ent(logic s, logic [5:0] m);
		swr = 1;
		swd = s;
		stp(1);
		swr = 0;
		`CHK("select", s, sel)
		sx = 1;
		stp(1);
		sx = 0;
		`CHK("entry", m, pmode)
	endtask
	task pulse_nmi;
		ntg = 1;
		stp(1);
		ntg = 0;
	endtask
	task results;
		$display("checks %0d fails %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	initial forever #20 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			fails++;
			results();
		end
	end

	initial begin
		void'($urandom(99));
		stp(16);
		rst_n = 1;
		stp(1);
		`CHK("mode_reset", 6'h01, pmode)
		ent(0, 6'h02);
		`CHK("cpu_halt", 1'b1, halt)
		ms = 8'($urandom);
		stp(1);
		`CHK("periph_clk", ~ms, pclk)
		irq = 1;
		for (k = 0; k < 7; k++) begin
			// Every mask mix but the one that lets the request through
			e = k + (k > 3);
			sen = e[2];
			prm = e[1];
			cpm = e[0];
			stp(2);
			`CHK("masked_irq", 6'h02, pmode)
		end
		sen = 1;
		prm = 0;
		cpm = 0;
		stp(1);
		`CHK("irq_wake", 6'h01, pmode)
		`CHK("int_exception", 1'b1, intx)
		irq = 0;
		$display("test sleep done");
		ent(0, 6'h02);
		itg = 1;
		stp(1);
		itg = 0;
		go("reset_state", 6'h10);
		go("reset_exit", 6'h01);
		`CHK("reset_exception", 1'b1, rstx)
		`CHK("reset_hold", 1'b1, lat >= 15)
		$display("test reset pin done");
		for (c = 0; c < 8; c++) begin
			sw = 3'(c);
			// External clock assumed, so any wait is legal; 8192 states run undivided
			pd = c ? 2'($urandom_range(3)) : 2'h0;
			ent(1, 6'h04);
			ext = 3'(1 << (c % 3));
			stp(3);
			`CHK("ext_disabled", 6'h04, pmode)
			een = 3'h7;
			cpm = 1;
			stp(3);
			`CHK("ext_masked", 6'h04, pmode)
			cpm = 0;
			go("settle", 6'h08);
			ext = '0;
			een = '0;
			go("wake_run", 6'h01);
			e = st[c] << pd;
			`CHK("settle_len", 1'b1, lat >= e && lat <= e + 5)
			`CHK("int_exception", 1'b1, intx)
			`CHK("select_kept", 1'b1, sel)
		end
		$display("test settle codes done");
		// Reset in mid-run from standby
		ent(1, 6'h04);
		rst_n = 0;
		stp(2);
		rst_n = 1;
		stp(1);
		`CHK("mid_reset_mode", 6'h01, pmode)
		`CHK("mid_reset_select", 1'b0, sel)
		`CHK("mid_reset_osc", 1'b1, osc)
		$display("test mid reset done");
		sw = 3'h6;
		pd = 2'h0;
		for (k = 0; k < 2; k++) begin
			eg = k[0];
			ent(1, 6'h04);
			if (nmi === k[0]) begin
				pulse_nmi();
				stp(3);
				`CHK("wrong_edge", 6'h04, pmode)
			end
			pulse_nmi();
			go("nmi_wake", 6'h08);
			go("nmi_run", 6'h01);
		end
		$display("test wake edge done");
		for (k = 0; k < 2; k++) begin
			ent(k[0], k ? 6'h04 : 6'h02);
			dpn = 0;
			stp(2);
			`CHK("hw_standby", 6'h20, pmode)
			`CHK("hw_flag", 1'b1, hws)
			`CHK("osc_off", 1'b0, osc)
			dpn = 1;
			go("hw_exit", 6'h01);
		end
		$display("test standby pin done");
		results();
	end
endmodule // sleep_standby_power_control_tb_top

`default_nettype wire
